// ---- src/rre_exec.v ----
/*
 * Execution of return and rotate-through-carry instructions.
 * Assumes decode presents one op with a start pulse and waits for done.
 * File register data is read combinationally from the register file.
 */
// Overview of operation
// - Interrupt return pops stack, loads counter
// - Interrupt return sets global enable, flags unchanged
// - Interrupt return: one word, two cycles
// - Subroutine return pops stack into counter
// - Subroutine return takes two cycles
// - Literal return loads accumulator and counter
// - Literal return: one word, two cycles
// - Rotate left through carry, msb out
// - Rotate left destination bit selects target
// - Rotate right through carry, lsb out
// - Rotate right destination bit selects target
// - Rotate left one cycle, carry and result written
`timescale 1ns/1ps
`default_nettype none
`include "rre_defs.vh"

module rre_exec (
  // Clock and reset
  input wire clock_i,
  input wire arst_n_i,
  // Instruction from decode
  input wire start_i,
  input wire [`RRE_OP_W-1:0] op_i,
  input wire [`RRE_DATA_W-1:0] literal_i,
  input wire [`RRE_ADDR_W-1:0] faddr_i,
  input wire dest_i,
  // Core state
  input wire [`RRE_DATA_W-1:0] fdata_i,
  input wire carry_i,
  input wire [`RRE_PC_W-1:0] stack_top_entry_i,
  input wire [4:0] stack_ptr_i,
  // Results
  output reg done_o,
  output reg busy_o,
  output reg pc_we_o,
  output reg [`RRE_PC_W-1:0] program_counter_o,
  output reg stack_we_o,
  output reg [4:0] stack_ptr_o,
  output reg global_irq_enable_set_o,
  output reg w_we_o,
  output reg [`RRE_DATA_W-1:0] w_data_o,
  output reg f_we_o,
  output reg [`RRE_ADDR_W-1:0] f_addr_o,
  output reg [`RRE_DATA_W-1:0] f_data_o,
  output reg carry_we_o,
  output reg carry_o
);

  //////////////////////////////////////////////////////////////////////////
  // States
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RET2 = 2'h1;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`RRE_OP_W-1:0] op_q;
  reg [`RRE_OP_W-1:0] op_d;
  reg [`RRE_DATA_W-1:0] lit_q;
  reg [`RRE_DATA_W-1:0] lit_d;

  reg done_d;
  reg busy_d;
  reg pc_we_d;
  reg [`RRE_PC_W-1:0] pc_d;
  reg stack_we_d;
  reg gie_d;
  reg w_we_d;
  reg [`RRE_DATA_W-1:0] w_d;
  reg f_we_d;
  reg [`RRE_DATA_W-1:0] f_d;
  reg carry_we_d;
  reg carry_d;

  wire [`RRE_DATA_W-1:0] rot_result;
  wire rot_carry;
  wire [4:0] ptr_next;
  wire pop_now;

  //////////////////////////////////////////////////////////////////////////
  // Return op test
  function is_return;
    input [`RRE_OP_W-1:0] op;
    begin
      is_return = (op == `RRE_OP_RETI) || (op == `RRE_OP_RET) ||
                  (op == `RRE_OP_RETK);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Datapath helpers
  rre_rotate u_rotate (
    .value_i(fdata_i),
    .carry_i(carry_i),
    .left_i(op_i == `RRE_OP_RLC),
    .result_o(rot_result),
    .carry_o(rot_carry)
  );

  assign pop_now = (state_q == ST_RET2) && is_return(op_q);

  rre_stack_pop u_pop (
    .ptr_i(stack_ptr_i),
    .pop_i(pop_now),
    .ptr_o(ptr_next)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state and outputs
  always @* begin
    state_d = state_q;
    op_d = op_q;
    lit_d = lit_q;
    done_d = 1'b0;
    busy_d = 1'b0;
    pc_we_d = 1'b0;
    pc_d = program_counter_o;
    stack_we_d = 1'b0;
    gie_d = 1'b0;
    w_we_d = 1'b0;
    w_d = w_data_o;
    f_we_d = 1'b0;
    f_d = f_data_o;
    carry_we_d = 1'b0;
    carry_d = carry_o;
    case (state_q)
      ST_IDLE: begin
        if (start_i) begin
          if (is_return(op_i)) begin
            // First of two cycles
            op_d = op_i;
            lit_d = literal_i;
            busy_d = 1'b1;
            state_d = ST_RET2;
          end else if (op_i == `RRE_OP_RLC || op_i == `RRE_OP_RRC) begin
            done_d = 1'b1;
            carry_we_d = 1'b1;
            carry_d = rot_carry;
            if (dest_i) begin
              f_we_d = 1'b1;
              f_d = rot_result;
            end else begin
              w_we_d = 1'b1;
              w_d = rot_result;
            end
          end else begin
            done_d = 1'b0;
          end
        end
      end
      ST_RET2: begin
        // Second cycle: pop and redirect
        done_d = 1'b1;
        pc_we_d = 1'b1;
        pc_d = stack_top_entry_i;
        stack_we_d = 1'b1;
        if (op_q == `RRE_OP_RETI) begin
          gie_d = 1'b1;
        end
        if (op_q == `RRE_OP_RETK) begin
          w_we_d = 1'b1;
          w_d = lit_q;
        end
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      op_q <= `RRE_OP_NONE;
      lit_q <= `RRE_DATA_RST;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      pc_we_o <= 1'b0;
      program_counter_o <= `RRE_PC_RST;
      stack_we_o <= 1'b0;
      stack_ptr_o <= `RRE_PTR_RST;
      global_irq_enable_set_o <= 1'b0;
      w_we_o <= 1'b0;
      w_data_o <= `RRE_DATA_RST;
      f_we_o <= 1'b0;
      f_addr_o <= `RRE_ADDR_RST;
      f_data_o <= `RRE_DATA_RST;
      carry_we_o <= 1'b0;
      carry_o <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      lit_q <= lit_d;
      done_o <= done_d;
      busy_o <= busy_d;
      pc_we_o <= pc_we_d;
      program_counter_o <= pc_d;
      stack_we_o <= stack_we_d;
      stack_ptr_o <= ptr_next;
      global_irq_enable_set_o <= gie_d;
      w_we_o <= w_we_d;
      w_data_o <= w_d;
      f_we_o <= f_we_d;
      if (start_i && state_q == ST_IDLE) begin
        f_addr_o <= faddr_i;
      end
      f_data_o <= f_d;
      carry_we_o <= carry_we_d;
      carry_o <= carry_d;
    end
  end

endmodule // rre_exec
`default_nettype wire

// ---- src/rre_defs.vh ----
/*
 * Constants for the return and rotate execution block.
 * Assumes a 14-bit instruction word, 15-bit program counter, 8-bit data.
 */
`ifndef RRE_DEFS_VH
`define RRE_DEFS_VH

// Operation codes presented by decode
`define RRE_OP_W 3
`define RRE_OP_NONE 3'h0
`define RRE_OP_RETI 3'h1
`define RRE_OP_RET 3'h2
`define RRE_OP_RETK 3'h3
`define RRE_OP_RLC 3'h4
`define RRE_OP_RRC 3'h5

// Widths
`define RRE_PC_W 15
`define RRE_DATA_W 8
`define RRE_ADDR_W 7

// Cycle counts
`define RRE_RET_CYCLES 2
`define RRE_ROT_CYCLES 1

// Reset values
`define RRE_PC_RST 15'h0000
`define RRE_DATA_RST 8'h00
`define RRE_PTR_RST 5'h00
`define RRE_ADDR_RST 7'h00

`endif

// ---- src/rre_rotate.v ----
/*
 * Rotate-through-carry datapath, combinational.
 * Assumes operand and carry are stable for the cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rre_defs.vh"

module rre_rotate (
  // Operands
  input wire [7:0] value_i,
  input wire carry_i,
  input wire left_i,
  // Results
  output reg [7:0] result_o,
  output reg carry_o
);

  always @* begin
    if (left_i) begin
      result_o = {value_i[6:0], carry_i};
      carry_o = value_i[7];
    end else begin
      result_o = {carry_i, value_i[7:1]};
      carry_o = value_i[0];
    end
  end

endmodule // rre_rotate
`default_nettype wire

// ---- src/rre_stack_pop.v ----
/*
 * Return stack pointer decrement helper.
 * Assumes a 5-bit pointer that wraps; storage lives in the core.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rre_defs.vh"

module rre_stack_pop (
  // Pointer
  input wire [4:0] ptr_i,
  input wire pop_i,
  output wire [4:0] ptr_o
);

  assign ptr_o = pop_i ? ptr_i - 5'h01 : ptr_i;

endmodule // rre_stack_pop
`default_nettype wire

// ---- testbench/rre_exec_props.sv ----
/* Port-level checks for rre_exec.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module rre_exec_props (
  // Clock, reset and inputs
  input wire logic clock_i, arst_n_i, start_i, dest_i, carry_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] literal_i, fdata_i,
  input wire logic [6:0] faddr_i,
  input wire logic [14:0] stack_top_entry_i,
  input wire logic [4:0] stack_ptr_i,
  // Outputs
  input wire logic done_o, busy_o, pc_we_o, stack_we_o, global_irq_enable_set_o,
  input wire logic w_we_o, f_we_o, carry_we_o, carry_o,
  input wire logic [14:0] program_counter_o,
  input wire logic [4:0] stack_ptr_o,
  input wire logic [7:0] w_data_o, f_data_o,
  input wire logic [6:0] f_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire acc = start_i & !busy_o;
  wire ret = acc & (op_i != 3'h0) & (op_i < 3'h4);
  ////////////////////////////////////////////////////////////////////////
  property p_rol;
    acc && op_i == 3'h4 |=> done_o && carry_we_o && carry_o == $past(fdata_i[7]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left carry wrong");
  property p_rolw;
    acc && op_i == 3'h4 && !dest_i |=> w_we_o && !f_we_o
      && w_data_o == {$past(fdata_i[6:0]), $past(carry_i)};
  endproperty
  a_rolw: assert property (p_rolw) else $error("rotate left result wrong");
  property p_rorf;
    acc && op_i == 3'h5 && dest_i |=> done_o && f_we_o && !w_we_o && f_addr_o == $past(faddr_i)
      && f_data_o == {$past(carry_i), $past(fdata_i[7:1])} && carry_o == $past(fdata_i[0]);
  endproperty
  a_rorf: assert property (p_rorf) else $error("rotate right result wrong");
  property p_ret;
    ret |=> busy_o && !done_o ##1 done_o && pc_we_o
      && program_counter_o == $past(stack_top_entry_i);
  endproperty
  a_ret: assert property (p_ret) else $error("return timing wrong");
  property p_pop;
    ret |=> ##1 stack_we_o && stack_ptr_o == $past(stack_ptr_i) - 5'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  property p_gie;
    acc && op_i == 3'h1 |=> ##1 global_irq_enable_set_o;
  endproperty
  a_gie: assert property (p_gie) else $error("enable not set");
  property p_lit;
    acc && op_i == 3'h3 |=> ##1 w_we_o && w_data_o == $past(literal_i, 2);
  endproperty
  a_lit: assert property (p_lit) else $error("literal not loaded");
  property p_flag;
    ret |=> !carry_we_o ##1 !carry_we_o
      && global_irq_enable_set_o == ($past(op_i, 2) == 3'h1);
  endproperty
  a_flag: assert property (p_flag) else $error("return touched flags");
  c_rot: cover property (acc && op_i == 3'h4 && dest_i);
  c_ret: cover property (ret ##2 done_o);
  c_ref: cover property (busy_o && start_i);
endmodule // rre_exec_props
bind rre_exec rre_exec_props u_props (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
/* Self-checking bench for rre_exec, fixed seed.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i = 0, arst_n_i = 0, start_i = 0, dest_i = 0, carry_i = 0;
  logic [2:0] op_i = 0;
  logic [7:0] literal_i = 0, fdata_i = 0;
  logic [6:0] faddr_i = 0;
  logic [14:0] stack_top_entry_i = 0;
  logic [4:0] stack_ptr_i = 0;
  wire done_o, busy_o, pc_we_o, stack_we_o, global_irq_enable_set_o;
  wire w_we_o, f_we_o, carry_we_o, carry_o;
  wire [14:0] program_counter_o;
  wire [4:0] stack_ptr_o;
  wire [7:0] w_data_o, f_data_o;
  wire [6:0] f_addr_o;
  integer seed = 92234, errors = 0, n_compared = 0, cyc = 0, i;
  rre_exec dut (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .start_i(start_i),
    .op_i(op_i),
    .literal_i(literal_i),
    .faddr_i(faddr_i),
    .dest_i(dest_i),
    .fdata_i(fdata_i),
    .carry_i(carry_i),
    .stack_top_entry_i(stack_top_entry_i),
    .stack_ptr_i(stack_ptr_i),
    .done_o(done_o),
    .busy_o(busy_o),
    .pc_we_o(pc_we_o),
    .program_counter_o(program_counter_o),
    .stack_we_o(stack_we_o),
    .stack_ptr_o(stack_ptr_o),
    .global_irq_enable_set_o(global_irq_enable_set_o),
    .w_we_o(w_we_o),
    .w_data_o(w_data_o),
    .f_we_o(f_we_o),
    .f_addr_o(f_addr_o),
    .f_data_o(f_data_o),
    .carry_we_o(carry_we_o),
    .carry_o(carry_o)
  );
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Returns {carry, result}
  function logic [8:0] rot(input logic l, input logic [7:0] v, input logic c);
    rot = l ? {v, c} : {v[0], c, v[7:1]};
  endfunction
  task one_op(input logic [2:0] op);
    logic [8:0] r;
    op_i = op;
    start_i = 1;
    {literal_i, fdata_i, faddr_i, dest_i, carry_i} = 25'($random(seed));
    r = rot(op == 3'h4, fdata_i, carry_i);
    @(posedge clock_i);
    #2;
    if (op == 3'h4 || op == 3'h5) begin
      chk("carry", {2'b11, r[8]}, {done_o, carry_we_o, carry_o});
      chk("dest", {dest_i, !dest_i, r[7:0]}, {f_we_o, w_we_o, dest_i ? f_data_o : w_data_o});
      chk("addr", faddr_i, f_addr_o);
    end else if (op != 3'h0 && op < 3'h4) begin
      chk("busy", 2'b10, {busy_o, done_o});
      {stack_top_entry_i, stack_ptr_i} = 20'($random(seed));
      op_i = 3'h4;
      @(posedge clock_i);
      #2;
      chk("pc", {1'b1, stack_top_entry_i}, {pc_we_o, program_counter_o});
      chk("pop", {1'b1, stack_ptr_i - 5'h1}, {stack_we_o, stack_ptr_o});
      chk("irq", {op == 3'h1, 1'b0, op == 3'h3}, {global_irq_enable_set_o, carry_we_o, w_we_o});
      if (op == 3'h3) chk("lit", literal_i, w_data_o);
    end else chk("none", 0, done_o);
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    #2;
    chk("reset", 0, {done_o, pc_we_o, program_counter_o});
    arst_n_i = 1;
    $display("reset test done");
    for (i = 0; i < 8; i++) one_op(i[2:0]);
    for (i = 0; i < 80; i++) one_op(3'($random(seed)));
    start_i = 0;
    repeat (3) @(posedge clock_i);
    $display("random test done");
    #2;
    start_i = 1;
    op_i = 3'h2;
    @(posedge clock_i);
    #2;
    arst_n_i = 0;
    #1;
    chk("midreset", 0, {busy_o, done_o, pc_we_o, stack_we_o, program_counter_o});
    repeat (2) @(posedge clock_i);
    #2;
    arst_n_i = 1;
    one_op(3'h5);
    start_i = 0;
    $display("reset in mid-run test done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
